/* File: bench/tao_conv_model.sv */
// Converter model answering each start request that is not aborted after a short delay
`timescale 1ns/1ps
`default_nettype none
module tao_conv_model (
	input wire logic clk,
	input wire logic conv_start,
	input wire logic conv_abort,
	input wire logic [7:0] temp,
	output logic conv_done,
	output logic [7:0] conv_data
);
	logic [1:0] cnt_q = 2'h0;
	always_ff @(posedge clk) begin
		if (conv_start)
			cnt_q <= 2'h3;
		else if (conv_abort)
			cnt_q <= 2'h0;
		else if (cnt_q != 2'h0)
			cnt_q <= cnt_q - 2'h1;
	end
	assign conv_done = cnt_q == 2'h1;
	// Data is only meaningful with done
	assign conv_data = conv_done ? temp : ~temp;
endmodule : tao_conv_model
`default_nettype wire

/* File: bench/tb_top.sv */
// Testbench for the alarm block
`timescale 1ns/1ps
`default_nettype none
`include "tao_defines.svh"
module tb_top;
	logic clk, rst_n, wr_en, rd_en, hdr_valid, hdr_ack, ara_won, ara_lost;
	logic conv_start, conv_abort, conv_done, alert_o, alert_oe, overtemp_o, overtemp_oe, standby;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data, ara_byte, conv_data, temp, d;
	logic [6:0] hdr_addr;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	int starts = 0;
	int aborts = 0;
	int base = 0;
	tao_alarm #(.W(8)) i_dut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
		.hdr_valid(hdr_valid), .hdr_addr(hdr_addr), .hdr_ack(hdr_ack), .ara_byte(ara_byte),
		.ara_won(ara_won), .ara_lost(ara_lost), .conv_start(conv_start),
		.conv_abort(conv_abort), .conv_done(conv_done), .conv_data(conv_data),
		.alert_o(alert_o), .alert_oe(alert_oe), .overtemp_o(overtemp_o),
		.overtemp_oe(overtemp_oe), .standby(standby));
	tao_conv_model i_conv (.clk(clk), .conv_start(conv_start), .conv_abort(conv_abort),
		.temp(temp), .conv_done(conv_done), .conv_data(conv_data));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (conv_start)
			starts++;
		if (conv_abort)
			aborts++;
		if (cycles == 3000) begin
			fails++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = v;
		@(negedge clk);
		wr_en = 1'b0;
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		rd_en = 1'b1;
		rd_addr = a;
		@(negedge clk);
		rd_en = 1'b0;
		d = rd_data;
		@(negedge clk);
	endtask : rd
	task automatic pins(input logic a, input logic t);
		repeat (14) @(negedge clk);
		chk("alert pin", {6'h0, alert_o, alert_oe}, {7'h0, a});
		chk("overtemp pin", {6'h0, overtemp_o, overtemp_oe}, {7'h0, t});
	endtask : pins
	// Alert response read; won or lost follows an ack
	task automatic ara(input logic exp_ack, input logic lost);
		hdr_valid = 1'b1;
		hdr_addr = `TAO_ARA_ADDR;
		#1;
		chk("ara ack", {7'h0, hdr_ack}, {7'h0, exp_ack});
		@(negedge clk);
		hdr_valid = 1'b0;
		ara_won = exp_ack & ~lost;
		ara_lost = exp_ack & lost;
		@(negedge clk);
		ara_won = 1'b0;
		ara_lost = 1'b0;
	endtask : ara
	////////////////////////////////////////////////////////////////
	initial begin
		{clk, rst_n, wr_en, rd_en, hdr_valid, ara_won, ara_lost} = 7'h00;
		{wr_addr, wr_data, rd_addr, hdr_addr} = 31'h0;
		temp = 8'h20;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		rd(`TAO_RW_THYST);
		chk("hyst reset", d, 8'h0a);
		wr(`TAO_RW_THYST, 8'h05);
		rd(`TAO_RW_THYST);
		chk("hyst write", d, 8'h05);
		rd(`TAO_WR_SHOT);
		chk("wo read", d, 8'h00);
		hdr_valid = 1'b1;
		hdr_addr = `TAO_DEV_ADDR;
		#1;
		chk("own ack", {7'h0, hdr_ack}, 8'h01);
		@(negedge clk);
		hdr_valid = 1'b0;
		$display("test reset done");
		temp = 8'h60;
		pins(1'b1, 1'b1);
		chk("ara byte", ara_byte, 8'h99);
		ara(1'b1, 1'b1);
		pins(1'b1, 1'b1);
		temp = 8'h51;
		pins(1'b1, 1'b1);
		temp = 8'h50;
		pins(1'b1, 1'b0);
		rd(`TAO_RD_STATUS);
		chk("status", d, 8'h10);
		pins(1'b1, 1'b0);
		ara(1'b1, 1'b0);
		pins(1'b0, 1'b0);
		ara(1'b0, 1'b0);
		$display("test alert response done");
		// Enter standby on a start edge so exactly one conversion is cut off
		while (!conv_start) @(negedge clk);
		temp = 8'h33;
		wr(`TAO_WR_CFG, 8'h40);
		chk("standby", {7'h0, standby}, 8'h01);
		base = starts;
		repeat (30) @(negedge clk);
		chk("idle starts", 8'(starts - base), 8'h00);
		chk("aborts", 8'(aborts), 8'h01);
		rd(`TAO_RD_TEMP);
		chk("stby temp", d, 8'h50);
		temp = 8'h48;
		base = starts;
		wr(`TAO_WR_SHOT, 8'ha5);
		repeat (20) @(negedge clk);
		chk("shot starts", 8'(starts - base), 8'h01);
		rd(`TAO_RD_TEMP);
		chk("shot temp", d, 8'h48);
		wr(`TAO_WR_HI, 8'h40);
		pins(1'b1, 1'b0);
		$display("test standby done");
		wr(`TAO_WR_HI, 8'h55);
		rd(`TAO_RD_STATUS);
		chk("limit status", d, 8'h10);
		ara(1'b1, 1'b0);
		wr(`TAO_WR_CFG, 8'h80);
		temp = 8'h60;
		pins(1'b0, 1'b1);
		wr(`TAO_WR_CFG, 8'ha0);
		pins(1'b1, 1'b1);
		temp = 8'h50;
		pins(1'b0, 1'b0);
		$display("test mask and role done");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire

/* File: core/tao_alarm.sv */
// Limit alarm, over-temperature outputs, standby and one-shot control
// Summary of operation
// R1: Alarm pin pulls low when temperature above high limit or at/below low limit.
// R2: Alarm pin only pulls low or floats, never drives high.
// R3: Master answers a low alert line with a read to the response address.
// R4: While alarm asserted, acknowledge response-address read and return address with LSB 1.
// R5: Lowest address wins arbitration; loser keeps alarm and answers later.
// R6: Alarm released after address read, temperature back in range, status cleared.
// R7: Master repeats response-address reads while shared line stays low.
// R8: Standby bit stops converter, aborts conversion without update; serial port stays.
// R9: One-shot write in standby runs exactly one conversion, then standby again.
// R10: Data byte of a one-shot write is ignored.
// R11: Limit write in standby re-checks stored temperature and may assert alarm.
// R12: Limit alarm is maskable; over-temperature output cannot be masked.
// R13: Over-temperature output pulls low above the over-temperature limit.
// R14: Over-temperature output releases itself at limit minus hysteresis.
// R15: Hysteresis resets to 10 degrees, one degree per step, reprogrammable.
// R16: Alarm pin selectable as limit alarm or second over-temperature output.
// R17: Second over-temperature role uses high limit, unmasked, same hysteresis.
// R18: Device answers at one fixed seven-bit address, returned in alert response.
// R19: Limits are evaluated whenever a conversion result is stored.
`timescale 1ns/1ps
`default_nettype none
`include "tao_defines.svh"
module tao_alarm import tao_pkg::*; #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [W-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic hdr_valid,
	input wire logic [6:0] hdr_addr,
	output logic hdr_ack,
	output logic [7:0] ara_byte,
	input wire logic ara_won,
	input wire logic ara_lost,
	output logic conv_start,
	output logic conv_abort,
	input wire logic conv_done,
	input wire logic [W-1:0] conv_data,
	output logic alert_o,
	output logic alert_oe,
	output logic overtemp_o,
	output logic overtemp_oe,
	output logic standby
);
	if (W != 8) begin : g_bad_width
		$error("tao_alarm: only 8-bit registers supported");
	end

	tao_state_t s_q, s_d;
	logic stby, mask, pin2, hi_viol, lo_viol, viol, wr_limit;
	logic ot_main, ot_second, stat_rd, alarm_pin;

	////////////////////////////////////////////////////////////////////////
	// Comparators

	assign stby = s_q.cfg[`TAO_CFG_STBY_BIT];
	assign mask = s_q.cfg[`TAO_CFG_MASK_BIT];
	assign pin2 = s_q.cfg[`TAO_CFG_PIN2_BIT];
	assign hi_viol = $signed(s_q.temp) > $signed(s_q.hi); // R1
	assign lo_viol = $signed(s_q.temp) <= $signed(s_q.lo); // R1
	assign viol = hi_viol || lo_viol;
	assign wr_limit = wr_en && (wr_addr == `TAO_WR_HI || wr_addr == `TAO_WR_LO ||
		wr_addr == `TAO_RW_TLIM || wr_addr == `TAO_RW_THYST);
	assign stat_rd = rd_en && rd_addr == `TAO_RD_STATUS;

	tao_hyst #(.W(W)) u_ot_main (
		.clk(clk),
		.rst_n(rst_n),
		.eval(s_q.eval),
		.temp(s_q.temp),
		.limit(s_q.tlim),
		.hyst(s_q.thyst),
		.asserted(ot_main)
	);

	// Second output uses the high limit and the shared hysteresis
	tao_hyst #(.W(W)) u_ot_second (
		.clk(clk),
		.rst_n(rst_n),
		.eval(s_q.eval),
		.temp(s_q.temp),
		.limit(s_q.hi),
		.hyst(s_q.thyst),
		.asserted(ot_second)
	); // R17

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_d = s_q;
		s_d.eval = 1'b0;
		conv_start = 1'b0;
		conv_abort = 1'b0;
		if (wr_en) begin
			unique case (wr_addr)
				`TAO_WR_CFG: s_d.cfg = wr_data;
				`TAO_WR_HI: s_d.hi = wr_data;
				`TAO_WR_LO: s_d.lo = wr_data;
				`TAO_RW_TLIM: s_d.tlim = wr_data;
				`TAO_RW_THYST: s_d.thyst = wr_data; // R15
				`TAO_WR_SHOT: s_d.shot_pend = stby; // R9 R10
				default: ;
			endcase
		end
		if (wr_limit && stby) begin
			s_d.eval = 1'b1; // R11
		end
		unique case (s_q.conv)
			TAO_IDLE: begin
				if (!stby || s_q.shot_pend) begin
					conv_start = 1'b1;
					s_d.conv = TAO_BUSY;
					s_d.shot_run = stby; // R9
					s_d.shot_pend = 1'b0;
				end
			end
			TAO_BUSY: begin
				if (stby && !s_q.shot_run) begin
					conv_abort = 1'b1; // R8
					s_d.conv = TAO_IDLE;
				end else if (conv_done) begin
					s_d.temp = conv_data;
					s_d.eval = 1'b1; // R19
					s_d.shot_run = 1'b0;
					s_d.conv = TAO_IDLE;
				end
			end
		endcase
		if (stat_rd) begin
			s_d.stat_hi = 1'b0;
			s_d.stat_lo = 1'b0;
		end
		if (s_q.eval) begin
			if (hi_viol) s_d.stat_hi = 1'b1;
			if (lo_viol) s_d.stat_lo = 1'b1;
			if (viol && !mask) s_d.alert = 1'b1; // R12
		end
		// Losing arbitration leaves the alarm pending
		if (ara_won && s_q.alert && !ara_lost) begin
			s_d.serviced = 1'b1; // R5
		end
		if (s_q.alert && s_q.serviced && !viol && !s_q.stat_hi && !s_q.stat_lo &&
			!(s_q.eval && viol)) begin
			s_d.alert = 1'b0; // R6
			s_d.serviced = 1'b0;
		end
		if (rd_en) begin
			unique case (rd_addr)
				`TAO_RD_TEMP: s_d.rd_data = s_q.temp;
				`TAO_RD_STATUS: s_d.rd_data = {3'h0, s_q.stat_hi, s_q.stat_lo, 3'h0};
				`TAO_RD_CFG: s_d.rd_data = s_q.cfg;
				`TAO_RD_HI: s_d.rd_data = s_q.hi;
				`TAO_RD_LO: s_d.rd_data = s_q.lo;
				`TAO_RW_TLIM: s_d.rd_data = s_q.tlim;
				`TAO_RW_THYST: s_d.rd_data = s_q.thyst;
				default: s_d.rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{conv: TAO_IDLE, shot_pend: 1'b0, shot_run: 1'b0, eval: 1'b0,
				cfg: `TAO_RST_CFG, temp: `TAO_RST_TEMP, hi: `TAO_RST_HI,
				lo: `TAO_RST_LO, tlim: `TAO_RST_TLIM, thyst: `TAO_RST_THYST,
				stat_hi: 1'b0, stat_lo: 1'b0, alert: 1'b0, serviced: 1'b0,
				rd_data: 8'h00}; // R15
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign alarm_pin = pin2 ? ot_second : s_q.alert; // R16
	assign alert_o = 1'b0; // R2
	assign alert_oe = alarm_pin; // R2
	assign overtemp_o = 1'b0;
	assign overtemp_oe = ot_main; // R12
	assign rd_data = s_q.rd_data;
	assign standby = stby;
	assign ara_byte = {`TAO_DEV_ADDR, 1'b1}; // R4 R18
	assign hdr_ack = hdr_valid && (hdr_addr == `TAO_DEV_ADDR ||
		(hdr_addr == `TAO_ARA_ADDR && !pin2 && s_q.alert)); // R4 R18

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_alert_set: assert property (s_q.eval && viol && !mask |=> s_q.alert) // R1
		else $error("violation did not set alarm");
	a_alert_hold: assert property (s_q.alert && !s_q.serviced |=> s_q.alert) // R6
		else $error("alarm released before service");
	a_ara_ack: assert property (hdr_valid && hdr_addr == `TAO_ARA_ADDR && !pin2 // R4
		&& s_q.alert |-> hdr_ack && ara_byte == 8'h99)
		else $error("response address not acknowledged");
	a_ara_quiet: assert property (hdr_valid && hdr_addr == `TAO_ARA_ADDR && !s_q.alert // R4
		|-> !hdr_ack)
		else $error("response address acked while idle");
	a_lost_keep: assert property (s_q.alert && ara_lost && !s_q.serviced // R5
		|=> s_q.alert && !s_q.serviced)
		else $error("lost arbitration dropped alarm");
	a_stby_abort: assert property (s_q.conv == TAO_BUSY && stby && !s_q.shot_run // R8
		|-> conv_abort ##1 (s_q.conv == TAO_IDLE && !conv_start))
		else $error("standby did not abort");
	a_stby_hold: assert property (conv_abort |=> $stable(s_q.temp)) // R8
		else $error("aborted conversion updated value");
	a_shot_once: assert property (stby && s_q.conv == TAO_IDLE && !s_q.shot_pend
		|-> !conv_start) // R9
		else $error("conversion started in standby");
	a_limit_eval: assert property (wr_limit && stby |=> s_q.eval) // R11
		else $error("limit write not re-evaluated");
	a_mask_block: assert property (mask && !s_q.alert |=> !s_q.alert) // R12
		else $error("masked alarm asserted");
	a_pin_role: assert property (pin2 |-> alert_oe == ot_second) // R16
		else $error("pin role mismatch");
	a_pin_drive: assert property (alert_o == 1'b0 && overtemp_o == 1'b0) // R2
		else $error("open drain pin driven high");

	c_alert_cycle: cover property (s_q.alert ##[1:50] !s_q.alert);
	c_one_shot: cover property (stby && conv_start ##[1:50] conv_done);
	c_overtemp: cover property (overtemp_oe ##[1:50] !overtemp_oe);
endmodule : tao_alarm
`default_nettype wire

/* File: core/tao_defines.svh */
// Register offsets, field positions, reset values and addresses of the alarm block
`ifndef TAO_DEFINES_SVH
`define TAO_DEFINES_SVH

`define TAO_RD_TEMP 8'h00
`define TAO_RD_STATUS 8'h02
`define TAO_RD_CFG 8'h03
`define TAO_RD_HI 8'h05
`define TAO_RD_LO 8'h06
`define TAO_WR_CFG 8'h09
`define TAO_WR_HI 8'h0b
`define TAO_WR_LO 8'h0c
`define TAO_WR_SHOT 8'h0f
`define TAO_RW_TLIM 8'h20
`define TAO_RW_THYST 8'h21

`define TAO_CFG_PIN2_BIT 5
`define TAO_CFG_STBY_BIT 6
`define TAO_CFG_MASK_BIT 7
`define TAO_STAT_LO_BIT 3
`define TAO_STAT_HI_BIT 4

`define TAO_RST_CFG 8'h00
`define TAO_RST_TEMP 8'h00
`define TAO_RST_HI 8'h55
`define TAO_RST_LO 8'h00
`define TAO_RST_TLIM 8'h55
`define TAO_RST_THYST 8'h0a

`define TAO_DEV_ADDR 7'h4c
`define TAO_ARA_ADDR 7'h0c

`endif

/* File: core/tao_hyst.sv */
// Over-temperature comparator with hysteresis release
`timescale 1ns/1ps
`default_nettype none
module tao_hyst import tao_pkg::*; #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic eval,
	input wire logic [W-1:0] temp,
	input wire logic [W-1:0] limit,
	input wire logic [W-1:0] hyst,
	output logic asserted
);
	if (W < 2 || W > 16) begin : g_bad_width
		$error("tao_hyst: W out of range");
	end

	tao_hyst_state_t s_q, s_d;
	logic signed [W+1:0] t_s, lim_s, rel_s;

	always_comb begin
		t_s = (W+2)'($signed(temp));
		lim_s = (W+2)'($signed(limit));
		rel_s = lim_s - (W+2)'($signed({1'b0, hyst}));
		s_d = s_q;
		if (eval) begin
			if (t_s > lim_s) begin
				s_d.asserted = 1'b1; // R13
			end else if (t_s <= rel_s) begin
				s_d.asserted = 1'b0; // R14
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign asserted = s_q.asserted;

	a_hyst_set: assert property (@(posedge clk) disable iff (!rst_n) // R13
		eval && ($signed(temp) > $signed(limit)) |=> asserted)
		else $error("over-limit did not assert");
endmodule : tao_hyst
`default_nettype wire

/* File: core/tao_pkg.sv */
// Types shared by the alarm block
package tao_pkg;

	typedef enum logic [0:0] {
		TAO_IDLE = 1'b0,
		TAO_BUSY = 1'b1
	} tao_conv_t;

	typedef struct packed {
		tao_conv_t conv;
		logic shot_pend;
		logic shot_run;
		logic eval;
		logic [7:0] cfg;
		logic [7:0] temp;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [7:0] tlim;
		logic [7:0] thyst;
		logic stat_hi;
		logic stat_lo;
		logic alert;
		logic serviced;
		logic [7:0] rd_data;
	} tao_state_t;

	typedef struct packed {
		logic asserted;
	} tao_hyst_state_t;

endpackage : tao_pkg
